// ---- rtl/cssp_pkg.sv ----
/*
  Shared constants for the configurable serial slave port.
  Assumes a 40 MHz system clock.
*/
package cssp_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_115200 = 115200;
  // Oversampling by 16
  localparam int OVS = 16;
  localparam logic [2:0] BAUD_SEL_RST = 3'h1;
  localparam logic [1:0] PAR_SEL_RST = 2'h0;
  localparam logic STOP_SEL_RST = 1'h1;
  localparam logic [6:0] WAIT_MS_RST = 7'h14;
  localparam logic [6:0] WAIT_MS_MIN = 7'h05;
  localparam logic [6:0] WAIT_MS_MAX = 7'h63;
  localparam int MS_HZ = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_HZ;
  localparam int BLINK_SEC = 5;
  localparam int SEC_MS = 1000;
  localparam int HALF_SEC_MS = SEC_MS / 2;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PROTO_GENERIC = 2'h0;
  localparam logic [1:0] PROTO_PLC = 2'h1;
  localparam int DATA_BITS = 8;

  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int hz;
    case (sel)
      3'h0: hz = BAUD_4800;
      3'h2: hz = BAUD_19200;
      3'h3: hz = BAUD_38400;
      3'h4: hz = BAUD_115200;
      default: hz = BAUD_9600;
    endcase
    baud_div = 16'(CLK_HZ / (hz * OVS));
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] m);
    par_bit = (m == PAR_ODD) ? ~(^d) : (^d);
  endfunction
endpackage

// ---- rtl/cssp_tick.sv ----
/*
  Enable divider producing one-cycle pulses every DIV clock cycles.
  Assumes DIV is held stable while running.
*/
`timescale 1ns/1ps
module cssp_tick #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    cnt_next = cnt_reg + W'(1);
    tick_next = 1'b0;
    if (clr) begin
      cnt_next = '0;
    end else if (cnt_reg >= div - W'(1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ---- rtl/cssp_top.sv ----
/*
  Serial slave port: 8-bit async receiver and transmitter with selectable
  rate, parity and stop bits, reply delay, write permit and hub role.
  Assumes frame decoding outside; RX_PIN comes from an external pin.
*/
// Notes on behaviour
// - Rate selector 0..4 gives 4800..115200 bps, default 9600.
// - A changed rate takes effect only after power cycle (reset).
// - Loader port mode always runs 9600 bps, ignores selector.
// - At power-up, rate indicator blinks each second for 5 s.
// - Parity selector: 0 none, 1 even, 2 odd; default none.
// - Parity bit makes ones count even or odd as chosen.
// - Stop selector 0 gives one stop bit, 1 gives two; default two.
// - Reply held off 5 to 99 ms after request; default 20 ms.
// - Write permit off rejects every parameter-changing request.
// - Read requests are always answered.
// - Addresses 1, 5, 9, 13 are group relay masters; others slaves.
// - Slave hub modules use PLC protocol, generic only from reset to the first clock; PROTO_OUT resets to generic.
// - Hub exchange held off until setup is complete.
// - Upstream hub port exposes protocol only; downstream own settings.
`timescale 1ns/1ps
module cssp_top
  import cssp_pkg::*;
#(
  parameter int BLINK_MS = BLINK_SEC * SEC_MS,
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic RX_PIN,
  output logic TX_PIN,
  output logic TX_OE,
  input wire logic [2:0] BAUD_SEL,
  input wire logic [1:0] PARITY_SEL,
  input wire logic STOP_SEL,
  input wire logic [6:0] WAIT_MS,
  input wire logic WRITE_PERMIT,
  input wire logic LOADER_MODE,
  input wire logic [3:0] UNIT_ADDR_SW,
  input wire logic SETUP_DONE,
  input wire logic [1:0] UP_PROTO_SEL,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_PAR_ERR,
  output logic RX_FRAME_ERR,
  input wire logic REQ_DONE,
  input wire logic REQ_IS_WRITE,
  output logic REQ_REJECT,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_START,
  output logic TX_READY,
  output logic [4:0] RATE_LED,
  output logic GROUP_MASTER,
  output logic [1:0] PROTO_OUT,
  output logic EXCHANGE_EN
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA_S = 4'h4, RX_STOP = 4'h8
  } cssp_rx_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_WAIT = 5'h02, TX_BITS = 5'h04,
    TX_HOLD = 5'h08, TX_END = 5'h10
  } cssp_tx_t;

  // Pin synchroniser
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
    end else begin
      rx_s1_reg <= RX_PIN;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end

  // Settings latched once after reset release
  logic latched_reg, latched_next;
  logic [2:0] rate_reg, rate_next;
  logic [1:0] par_reg, par_next;
  logic stop_reg, stop_next;
  always_comb begin
    latched_next = 1'b1;
    rate_next = rate_reg;
    par_next = par_reg;
    stop_next = stop_reg;
    if (!latched_reg) begin
      rate_next = LOADER_MODE ? BAUD_SEL_RST : BAUD_SEL;
      par_next = PARITY_SEL;
      stop_next = STOP_SEL;
    end
    if (rate_next > 3'h4) begin
      rate_next = BAUD_SEL_RST;
    end
    // Unused parity code falls back to none
    if (par_next == 2'h3) begin
      par_next = PAR_SEL_RST;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      latched_reg <= 1'b0;
      rate_reg <= BAUD_SEL_RST;
      par_reg <= PAR_SEL_RST;
      stop_reg <= STOP_SEL_RST;
    end else begin
      latched_reg <= latched_next;
      rate_reg <= rate_next;
      par_reg <= par_next;
      stop_reg <= stop_next;
    end
  end

  // Oversample tick and millisecond tick
  logic os_tick, ms_tick;
  cssp_tick #(.W(16)) u_os (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .clr(1'b0),
    .div(baud_div(rate_reg)),
    .tick(os_tick)
  );
  cssp_tick #(.W(16)) u_ms (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .clr(1'b0),
    .div(16'(MS_DIV)),
    .tick(ms_tick)
  );

  // Receiver
  cssp_rx_t rx_st_reg, rx_st_next;
  logic [3:0] rx_os_reg, rx_os_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [8:0] rx_sh_reg, rx_sh_next;
  logic [7:0] rxd_reg, rxd_next;
  logic rxv_reg, rxv_next, pe_reg, pe_next, fe_reg, fe_next;
  logic [3:0] rx_nbits;
  assign rx_nbits = (par_reg == PAR_NONE) ? 4'h8 : 4'h9;
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_os_next = rx_os_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rxd_next = rxd_reg;
    rxv_next = 1'b0;
    pe_next = pe_reg;
    fe_next = fe_reg;
    case (rx_st_reg)
      RX_IDLE: begin
        rx_os_next = '0;
        // Falling edge only; a low bad stop starts nothing
        if (!rx_s2_reg && rx_s3_reg) begin
          rx_st_next = RX_START;
        end
      end
      RX_START: begin
        if (os_tick) begin
          rx_os_next = rx_os_reg + 4'h1;
          if (rx_os_reg == 4'h7) begin
            rx_os_next = '0;
            rx_bit_next = '0;
            rx_st_next = rx_s2_reg ? RX_IDLE : RX_DATA_S;
          end
        end
      end
      RX_DATA_S: begin
        if (os_tick) begin
          rx_os_next = rx_os_reg + 4'h1;
          if (rx_os_reg == 4'hf) begin
            rx_sh_next = {rx_s2_reg, rx_sh_reg[8:1]};
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == rx_nbits - 4'h1) begin
              rx_st_next = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (os_tick) begin
          rx_os_next = rx_os_reg + 4'h1;
          if (rx_os_reg == 4'hf) begin
            rx_st_next = RX_IDLE;
            rxd_next = (par_reg == PAR_NONE) ? rx_sh_reg[8:1]
                                              : rx_sh_reg[7:0];
            fe_next = !rx_s2_reg;
            pe_next = (par_reg != PAR_NONE) &&
              (par_bit(rx_sh_reg[7:0], par_reg) != rx_sh_reg[8]);
            rxv_next = rx_s2_reg && !((par_reg != PAR_NONE) &&
              (par_bit(rx_sh_reg[7:0], par_reg) != rx_sh_reg[8]));
          end
        end
      end
      default: rx_st_next = RX_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_st_reg <= RX_IDLE;
      rx_os_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rxd_reg <= '0;
      rxv_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_os_reg <= rx_os_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rxd_reg <= rxd_next;
      rxv_reg <= rxv_next;
      pe_reg <= pe_next;
      fe_reg <= fe_next;
    end
  end

  // Reply delay and write permit
  logic [6:0] wait_lim;
  assign wait_lim = (WAIT_MS < WAIT_MS_MIN) ? WAIT_MS_MIN :
                    (WAIT_MS > WAIT_MS_MAX) ? WAIT_MS_MAX : WAIT_MS;
  logic armed_reg, armed_next, rej_reg, rej_next;
  logic [6:0] wcnt_reg, wcnt_next;
  cssp_tx_t tx_st_reg, tx_st_next;
  logic [3:0] tx_os_reg, tx_os_next, tx_bit_reg, tx_bit_next;
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic txp_reg, txp_next, txoe_reg, txoe_next;
  logic [3:0] tx_nbits;
  assign tx_nbits = 4'h9 + ((par_reg == PAR_NONE) ? 4'h0 : 4'h1) +
                    (stop_reg ? 4'h2 : 4'h1);
  always_comb begin
    armed_next = armed_reg;
    rej_next = 1'b0;
    wcnt_next = wcnt_reg;
    tx_st_next = tx_st_reg;
    tx_os_next = tx_os_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    txp_next = txp_reg;
    txoe_next = txoe_reg;
    if (REQ_DONE) begin
      if (REQ_IS_WRITE && !WRITE_PERMIT) begin
        rej_next = 1'b1;
      end
      armed_next = 1'b1;
      wcnt_next = '0;
    end else if (armed_reg && ms_tick && wcnt_reg < wait_lim) begin
      wcnt_next = wcnt_reg + 7'h1;
    end
    case (tx_st_reg)
      TX_IDLE: begin
        if (TX_START) begin
          tx_sh_next = {2'h3, par_bit(TX_DATA, par_reg), TX_DATA};
          tx_st_next = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (armed_reg && wcnt_reg >= wait_lim && os_tick) begin
          armed_next = 1'b0;
          txoe_next = 1'b1;
          txp_next = 1'b0;
          tx_os_next = '0;
          tx_bit_next = '0;
          tx_st_next = TX_BITS;
        end
      end
      TX_BITS: begin
        if (os_tick) begin
          tx_os_next = tx_os_reg + 4'h1;
          if (tx_os_reg == 4'hf) begin
            tx_bit_next = tx_bit_reg + 4'h1;
            if (tx_bit_reg == tx_nbits - 4'h2) begin
              tx_st_next = TX_END;
            end
            txp_next = (tx_bit_reg < 4'h8) ? tx_sh_reg[tx_bit_reg[2:0]] :
              ((tx_bit_reg == 4'h8 && par_reg != PAR_NONE) ?
               tx_sh_reg[8] : 1'b1);
          end
        end
      end
      TX_END: begin
        if (os_tick) begin
          tx_os_next = tx_os_reg + 4'h1;
          if (tx_os_reg == 4'hf) begin
            txoe_next = 1'b0;
            tx_st_next = TX_IDLE;
          end
        end
      end
      default: tx_st_next = TX_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      armed_reg <= 1'b0;
      rej_reg <= 1'b0;
      wcnt_reg <= '0;
      tx_st_reg <= TX_IDLE;
      tx_os_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= '0;
      txp_reg <= 1'b1;
      txoe_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      rej_reg <= rej_next;
      wcnt_reg <= wcnt_next;
      tx_st_reg <= tx_st_next;
      tx_os_reg <= tx_os_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      txp_reg <= txp_next;
      txoe_reg <= txoe_next;
    end
  end

  // Power-up rate indicator and hub role
  logic [15:0] blink_reg, blink_next;
  logic [4:0] led_reg, led_next;
  logic gm_reg, gm_next, exch_reg, exch_next;
  logic [1:0] proto_reg, proto_next;
  always_comb begin
    blink_next = blink_reg;
    led_next = '0;
    if (ms_tick && blink_reg < 16'(BLINK_MS)) begin
      blink_next = blink_reg + 16'h1;
    end
    if (blink_reg < 16'(BLINK_MS) &&
        (blink_reg % 16'(SEC_MS)) < 16'(HALF_SEC_MS)) begin
      led_next[rate_reg] = 1'b1;
    end
    gm_next = (UNIT_ADDR_SW[1:0] == 2'h1);
    proto_next = gm_next ? UP_PROTO_SEL : PROTO_PLC;
    exch_next = SETUP_DONE;
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      blink_reg <= '0;
      led_reg <= '0;
      gm_reg <= 1'b0;
      proto_reg <= PROTO_GENERIC;
      exch_reg <= 1'b0;
    end else begin
      blink_reg <= blink_next;
      led_reg <= led_next;
      gm_reg <= gm_next;
      proto_reg <= proto_next;
      exch_reg <= exch_next;
    end
  end

  assign TX_PIN = txp_reg;
  assign TX_OE = txoe_reg;
  assign RX_DATA = rxd_reg;
  assign RX_VALID = rxv_reg;
  assign RX_PAR_ERR = pe_reg;
  assign RX_FRAME_ERR = fe_reg;
  assign REQ_REJECT = rej_reg;
  // Idle bit of the one-hot state
  assign TX_READY = tx_st_reg[0];
  assign RATE_LED = led_reg;
  assign GROUP_MASTER = gm_reg;
  assign PROTO_OUT = proto_reg;
  assign EXCHANGE_EN = exch_reg;
endmodule

// ---- verification/cssp_host.sv ----
/* Host model on the half-duplex link: sends characters, captures replies.
   Assumes the bench gives the bit length in clock cycles. */
`timescale 1ns/1ps
module cssp_host
  import cssp_pkg::*;
#(
  parameter int BIT = 336
) (
  input wire logic clk,
  input wire logic tx_pin,
  input wire logic tx_oe,
  output logic rx_pin
);
  initial rx_pin = 1'b1;
  task automatic put(input logic v);
    rx_pin <= v;
    repeat (BIT) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] d, input logic [1:0] pm,
                      input logic two, input logic bad_p, input logic bad_s);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(d[i]);
    if (pm != PAR_NONE) put(^d ^ (pm == PAR_ODD) ^ bad_p);
    put(~bad_s);
    if (two) put(1'b1);
    rx_pin <= 1'b1;
  endtask
  task automatic rcv(output logic [11:0] b, output int len, output int wt);
    b = 12'hfff;
    wt = 0;
    while (tx_oe !== 1'b1 && wt < 9000) begin
      @(posedge clk);
      wt++;
    end
    len = 0;
    while (tx_oe === 1'b1 && len < 9000) begin
      if (len % BIT == BIT / 2) b[len / BIT] = tx_pin;
      @(posedge clk);
      len++;
    end
  endtask
endmodule

// ---- verification/cssp_top_monitor.sv ----
/* Port checker for cssp_top, bound below.
   Assumes MS_DIV matches the design instance. */
`timescale 1ns/1ps
module cssp_mon
  import cssp_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic TX_PIN,
  input wire logic TX_OE,
  input wire logic [6:0] WAIT_MS,
  input wire logic WRITE_PERMIT,
  input wire logic [3:0] UNIT_ADDR_SW,
  input wire logic SETUP_DONE,
  input wire logic [1:0] UP_PROTO_SEL,
  input wire logic RX_VALID,
  input wire logic RX_PAR_ERR,
  input wire logic RX_FRAME_ERR,
  input wire logic REQ_DONE,
  input wire logic REQ_IS_WRITE,
  input wire logic REQ_REJECT,
  input wire logic [4:0] RATE_LED,
  input wire logic GROUP_MASTER,
  input wire logic [1:0] PROTO_OUT,
  input wire logic EXCHANGE_EN
);
  logic [31:0] since_reg, since_next, lo;
  logic seen_reg, seen_next;
  logic [6:0] w;
  // Cycles since the last request, and wait floor
  always_comb begin
    since_next = since_reg + {31'h0, ~&since_reg};
    seen_next = seen_reg | REQ_DONE;
    if (REQ_DONE) begin
      since_next = 32'h0;
    end
    w = (WAIT_MS < WAIT_MS_MIN) ? WAIT_MS_MIN : WAIT_MS;
    w = (w > WAIT_MS_MAX) ? WAIT_MS_MAX : w;
    lo = 32'(w - 7'h1) * 32'(MS_DIV);
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      since_reg <= 32'h0;
      seen_reg <= 1'b0;
    end else begin
      since_reg <= since_next;
      seen_reg <= seen_next;
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  a_write_reject: assert property (
    REQ_DONE && REQ_IS_WRITE && !WRITE_PERMIT |=> REQ_REJECT)
    else $error("denied write not rejected");
  a_read_answer: assert property (
    !$past(REQ_DONE && REQ_IS_WRITE && !WRITE_PERMIT) |-> !REQ_REJECT)
    else $error("reject without denied write");
  a_reply_wait: assert property (
    $rose(TX_OE) |-> seen_reg && since_reg >= lo)
    else $error("reply too early");
  a_start_low: assert property ($rose(TX_OE) |-> !TX_PIN)
    else $error("no start bit");
  a_stop_high: assert property (
    $fell(TX_OE) |-> $past(TX_PIN))
    else $error("stop bit not high");
  a_valid_clean: assert property (
    RX_VALID |-> !RX_PAR_ERR && !RX_FRAME_ERR)
    else $error("bad char delivered");
  a_group_master: assert property (
    $stable(UNIT_ADDR_SW) [*2]
    |-> GROUP_MASTER == (UNIT_ADDR_SW[1:0] == 2'h1))
    else $error("group master wrong");
  a_slave_proto: assert property (
    ($stable(UNIT_ADDR_SW) && $stable(UP_PROTO_SEL)) [*2]
    |-> PROTO_OUT == (GROUP_MASTER ? UP_PROTO_SEL : PROTO_PLC))
    else $error("protocol wrong");
  a_exch_hold: assert property (!SETUP_DONE |=> !EXCHANGE_EN)
    else $error("exchange before setup");
  a_exch_start: assert property (
    $rose(SETUP_DONE) |=> $rose(EXCHANGE_EN))
    else $error("exchange late");
  a_led_onehot: assert property ($onehot0(RATE_LED))
    else $error("rate indicator not one-hot");
  c_reject: cover property (REQ_REJECT);
  c_reply: cover property ($rose(TX_OE));
  c_rx: cover property (RX_VALID);
endmodule

bind cssp_top cssp_mon #(.MS_DIV(MS_DIV)) i_cssp_mon (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TX_PIN(TX_PIN), .TX_OE(TX_OE),
  .WAIT_MS(WAIT_MS), .WRITE_PERMIT(WRITE_PERMIT),
  .UNIT_ADDR_SW(UNIT_ADDR_SW), .SETUP_DONE(SETUP_DONE),
  .UP_PROTO_SEL(UP_PROTO_SEL), .RX_VALID(RX_VALID),
  .RX_PAR_ERR(RX_PAR_ERR), .RX_FRAME_ERR(RX_FRAME_ERR),
  .REQ_DONE(REQ_DONE), .REQ_IS_WRITE(REQ_IS_WRITE),
  .REQ_REJECT(REQ_REJECT), .RATE_LED(RATE_LED),
  .GROUP_MASTER(GROUP_MASTER), .PROTO_OUT(PROTO_OUT),
  .EXCHANGE_EN(EXCHANGE_EN));

// ---- verification/cssp_top_tb.sv ----
/* Bench for cssp_top with a host model on the link.
   Assumes shortened millisecond and blink counts. */
`timescale 1ns/1ps
module cssp_top_tb;
  import cssp_pkg::*;
  localparam int MSD = 40;
  localparam int BLK = 20;
  localparam int BIT = 16 * (CLK_HZ / (BAUD_115200 * OVS));
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_pin, tx_pin, tx_oe, stop_sel, permit, loader, setup;
  logic rx_valid, rx_perr, rx_ferr, req_done, req_wr, req_rej;
  logic tx_start, tx_ready, grp_m, exch;
  logic [2:0] baud_sel;
  logic [1:0] par_sel, up_proto, proto;
  logic [6:0] wait_ms;
  logic [3:0] addr_sw;
  logic [7:0] rx_data, tx_data, vdata;
  logic [4:0] led, seen;
  logic [11:0] b;
  int error_cnt = 0;
  int cmp_count = 0;
  int vcnt, len, wt, nb, we, n;
  int r_hz [7] = '{BAUD_4800, BAUD_9600, BAUD_19200, BAUD_38400,
                   BAUD_115200, BAUD_9600, BAUD_9600};
  always #12.5 clk = ~clk;
  cssp_top #(.BLINK_MS(BLK), .MS_DIV(MSD)) i_cssp_top (
    .SYS_CLK(clk), .RESET_N(rst_n), .RX_PIN(rx_pin), .TX_PIN(tx_pin),
    .TX_OE(tx_oe), .BAUD_SEL(baud_sel), .PARITY_SEL(par_sel),
    .STOP_SEL(stop_sel), .WAIT_MS(wait_ms), .WRITE_PERMIT(permit),
    .LOADER_MODE(loader), .UNIT_ADDR_SW(addr_sw), .SETUP_DONE(setup),
    .UP_PROTO_SEL(up_proto), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_PAR_ERR(rx_perr), .RX_FRAME_ERR(rx_ferr), .REQ_DONE(req_done),
    .REQ_IS_WRITE(req_wr), .REQ_REJECT(req_rej), .TX_DATA(tx_data),
    .TX_START(tx_start), .TX_READY(tx_ready), .RATE_LED(led),
    .GROUP_MASTER(grp_m), .PROTO_OUT(proto), .EXCHANGE_EN(exch));
  cssp_host #(.BIT(BIT)) i_cssp_host (.clk(clk), .tx_pin(tx_pin),
    .tx_oe(tx_oe), .rx_pin(rx_pin));
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      vcnt++;
      vdata = rx_data;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi,
                         input string m);
    cmp_count++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, v);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic [2:0] bs, input logic [1:0] p,
                      input logic s, input logic ld);
    rst_n = 1'b0;
    baud_sel = bs;
    par_sel = p;
    stop_sel = s;
    loader = ld;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
  endtask
  task automatic ask(input logic wr);
    req_wr = wr;
    req_done = 1'b1;
    cyc(1);
    req_done = 1'b0;
  endtask
  task automatic load(input logic [7:0] d);
    for (int k = 0; k < 100 && tx_ready !== 1'b1; k++) cyc(1);
    tx_data = d;
    tx_start = 1'b1;
    cyc(1);
    tx_start = 1'b0;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #4000000;
    error_cnt++;
    results();
  end
  initial begin
    {permit, setup, req_done, req_wr, tx_start} = 5'h10;
    {baud_sel, par_sel, stop_sel, loader} = 7'h22;
    {wait_ms, addr_sw, up_proto, tx_data} = 21'h0;
    cyc(1);
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 2; s++) begin
        boot(3'h4, p[1:0], s[0], 1'b0);
        nb = 10 + s + int'(p != 0);
        vcnt = 0;
        i_cssp_host.send(8'h96, p[1:0], s[0], 1'b0, 1'b0);
        cyc(4);
        chk(vcnt, 1, "rx count");
        chk(vdata, 8'h96, "rx data");
        chk(rx_perr | rx_ferr, 0, "rx flags");
        if (p != 0 && s == p - 1) begin
          i_cssp_host.send(8'h5a, p[1:0], s[0], 1'b1, 1'b0);
          cyc(4);
          chk(rx_perr, 1, "parity err");
          i_cssp_host.send(8'h33, p[1:0], s[0], 1'b0, 1'b1);
          cyc(4);
          chk(rx_ferr, 1, "frame err");
          chk(vcnt, 1, "bad kept out");
        end
        wait_ms = (p == 1) ? 7'h00 : (p == 2) ? 7'h7f : 7'h05;
        we = (p == 2) ? 99 : 5;
        ask(1'b0);
        load(8'hc5);
        chk(tx_ready, 0, "ready held");
        i_cssp_host.rcv(b, len, wt);
        chk(tx_ready, 1, "ready again");
        chk_rng(wt, (we-1) * MSD, (we+1) * MSD + BIT, "wait");
        chk(b[8:0], 9'h18a, "start and data");
        if (p != 0) chk(b[9], p == 2, "parity");
        chk(b[nb - 1] & b[nb - 1 - s], 1, "stop");
        chk_rng(len, nb * BIT - 2, nb * BIT + 2, "length");
      end
    end
    $display("test frames done");
    for (int k = 0; k < 4; k++) begin
      permit = k[1];
      ask(k[0]);
      chk(req_rej, k == 1, "reject");
      cyc(1);
      chk(req_rej, 0, "reject pulse");
    end
    $display("test permit done");
    wait_ms = 7'h05;
    for (int i = 0; i < 7; i++) begin
      boot(i > 5 ? 3'h4 : 3'(i), 2'h0, 1'b0, i > 5);
      seen = 5'h0;
      for (int k = 0; k < BLK * MSD; k++) begin
        seen = seen | led;
        cyc(1);
      end
      chk(seen, 5'h1 << ((i < 5) ? i : 1), "indicator");
      cyc(2 * MSD);
      chk(led, 0, "indicator off");
      baud_sel = baud_sel ^ 3'h1;
      ask(1'b0);
      load(8'hff);
      for (n = 0; n < 9000 && tx_oe !== 1'b1; n++) cyc(1);
      for (n = 0; n < 9000 && tx_pin === 1'b0; n++) cyc(1);
      we = 16 * (CLK_HZ / (r_hz[i] * OVS));
      chk_rng(n, we - 1, we + 1, "bit time");
    end
    $display("test rates done");
    up_proto = 2'h2;
    for (int a = 0; a < 16; a++) begin
      addr_sw = a[3:0];
      cyc(3);
      chk(grp_m, a[1:0] == 2'h1, "group master");
      chk(proto, a % 4 == 1 ? up_proto : PROTO_PLC, "proto");
    end
    $display("test address done");
    setup = 1'b1;
    chk(exch, 0, "exchange held");
    cyc(1);
    chk(exch, 1, "exchange on");
    $display("test setup done");
    results();
  end
endmodule
